// [common/tmr6_defs.svh]
`ifndef TMR6_DEFS_SVH
`define TMR6_DEFS_SVH

// ****************************************
// register map
// ****************************************
`define TMR6_ADDR_W        8
`define TMR6_DATA_W        8
`define TMR6_ADDR_CTRL     8'h16
`define TMR6_ADDR_CMP      8'h17
`define TMR6_CMP_RESET     8'hFF
`define TMR6_READ_IDLE     8'h00

// ****************************************
// control register fields
// ****************************************
`define TMR6_CTRL_START    5
`define TMR6_CTRL_SRC_HI   4
`define TMR6_CTRL_SRC_LO   2
`define TMR6_CTRL_MODE_HI  1
`define TMR6_CTRL_MODE_LO  0
`define TMR6_CTRL_PAD      2'h0

// ****************************************
// source clock codes and prescale shifts
// ****************************************
`define TMR6_SRC_EXT       3'h7
`define TMR6_SRC_SLOW_OK   3'h0
`define TMR6_SHIFT_SRC0    4'hB
`define TMR6_SHIFT_SRC1    4'h7
`define TMR6_SHIFT_SRC2    4'h5
`define TMR6_SHIFT_SRC3    4'h3
`define TMR6_SHIFT_SRC4    4'h2
`define TMR6_SHIFT_SRC5    4'h1
`define TMR6_SHIFT_SRC6    4'h0
`define TMR6_PRE_W         11

// ****************************************
// counter constants
// ****************************************
`define TMR6_CNT_ZERO      8'h00
`define TMR6_CNT_ONE       8'h01
`define TMR6_CNT_TOP       8'hFF

`endif

// [common/tmr6_pkg.sv]
package tmr6_pkg;

    typedef enum logic [1:0] {
        TMR6_MODE_TIMER    = 2'h0,
        TMR6_MODE_RESERVED = 2'h1,
        TMR6_MODE_DIVIDER  = 2'h2,
        TMR6_MODE_PWM      = 2'h3
    } tmr6_mode_t;

    typedef struct packed {
        logic       start_bit;
        logic [2:0] source_clock_select;
        tmr6_mode_t mode_field;
    } tmr6_ctrl_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tmr6_bus_req_t;

endpackage

// [hdl/tmr6_edge_sync.sv]
`timescale 1ns/100ps
module tmr6_edge_sync
    import tmr6_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic nrst,
    input  wire logic pin_in,
    output logic      rise,
    output logic      fall
);

    logic sync_a;
    logic sync_b;
    logic sync_c;

    // two flops before any logic looks at the pin
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            sync_c <= 1'b0;
        end else begin
            sync_a <= pin_in;
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    assign rise = sync_b & ~sync_c;
    assign fall = ~sync_b & sync_c;

endmodule

// [hdl/tmr6_prescaler.sv]
`timescale 1ns/100ps
`include "tmr6_defs.svh"
module tmr6_prescaler
    import tmr6_pkg::*;
#(
    parameter int PRE_W = `TMR6_PRE_W
)
(
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    input  wire logic       run,
    input  wire logic       low_speed_mode,
    input  wire logic [2:0] source_clock_select,
    output logic            tick
);

    logic [PRE_W-1:0] pre_cnt;
    logic [PRE_W-1:0] tick_mask;
    logic             src_ok;

    function automatic logic [3:0] src_shift(input logic [2:0] sel);
        unique case (sel)
            3'h0:    src_shift = `TMR6_SHIFT_SRC0;
            3'h1:    src_shift = `TMR6_SHIFT_SRC1;
            3'h2:    src_shift = `TMR6_SHIFT_SRC2;
            3'h3:    src_shift = `TMR6_SHIFT_SRC3;
            3'h4:    src_shift = `TMR6_SHIFT_SRC4;
            3'h5:    src_shift = `TMR6_SHIFT_SRC5;
            3'h6:    src_shift = `TMR6_SHIFT_SRC6;
            default: src_shift = `TMR6_SHIFT_SRC6;
        endcase
    endfunction

    // only the slowest tap survives in the low-speed modes
    assign src_ok    = (source_clock_select != `TMR6_SRC_EXT) &&
                       (!low_speed_mode || source_clock_select == `TMR6_SRC_SLOW_OK);
    assign tick_mask = PRE_W'((PRE_W+1)'(1) << src_shift(source_clock_select)) - PRE_W'(1);
    assign tick      = run && src_ok && ((pre_cnt & tick_mask) == tick_mask);

    // restarting from zero keeps the first interval a full one
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pre_cnt <= '0;
        end else if (!run) begin
            pre_cnt <= '0;
        end else begin
            pre_cnt <= pre_cnt + PRE_W'(1);
        end
    end

endmodule

// [hdl/tmr6_top.sv]
// Operation
// - timer mode counts internal source ticks
// - timer match interrupts, clears, keeps counting
// - event mode counts rising pin edges
// - event match acts on next falling edge
// - no event counting in low-speed modes
// - divider match toggles pin, interrupts, clears
// - divider pin high while stopped
// - pwm match drives pin low, no clear
// - pwm overflow drives pin high, interrupts
// - pwm pin high while stopped
// - pwm compare writes wait for period end
// - start loads compare into pwm stage
// - pwm only in full-speed or idle
// - mode field decode 00 10 11
// - start clear stops and clears counter
// - full stop entry clears start bit
`timescale 1ns/100ps
`include "tmr6_defs.svh"
module tmr6_top
    import tmr6_pkg::*;
#(
    parameter int CNT_W = `TMR6_DATA_W
)
(
    input  wire logic             clk_sys,
    input  wire logic             nrst,
    input  wire tmr6_bus_req_t    bus_req,
    output logic [7:0]            rdata,
    input  wire logic             low_speed_mode,
    input  wire logic             stop_mode_entry,
    input  wire logic             event_input_pin,
    output logic                  divider_output_pin,
    output logic                  pwm_output_pin_n,
    output logic                  timer_interrupt
);

    // ****************************************
    // declarations
    // ****************************************
    tmr6_ctrl_t       ctrl;
    tmr6_ctrl_t       next_ctrl;
    logic [CNT_W-1:0] compare_value_reg;
    logic [CNT_W-1:0] pwm_active_cmp;
    logic [CNT_W-1:0] counter;
    logic [CNT_W-1:0] next_counter;
    logic [CNT_W-1:0] count_plus;
    logic [7:0]       next_rdata;
    logic [7:0]       ctrl_rd_view;
    logic             start_prev;
    logic             start_rise;
    logic             wr_ctrl;
    logic             wr_cmp;
    logic             rd_ctrl;
    logic             rd_cmp;
    logic             tick;
    logic             ev_rise;
    logic             ev_fall;
    logic             is_timer;
    logic             is_event;
    logic             is_divider;
    logic             is_pwm;
    logic             count_step;
    logic             tick_match;
    logic             event_match;
    logic             pwm_match;
    logic             pwm_overflow;
    logic             clear_hit;
    logic             next_divider;
    logic             next_pwm_n;

    function automatic logic [CNT_W-1:0] inc_cnt(input logic [CNT_W-1:0] v);
        inc_cnt = v + CNT_W'(`TMR6_CNT_ONE);
    endfunction

    // ****************************************
    // register bus decode
    // ****************************************
    assign wr_ctrl = bus_req.wr && (bus_req.addr == `TMR6_ADDR_CTRL);
    assign wr_cmp  = bus_req.wr && (bus_req.addr == `TMR6_ADDR_CMP);
    assign rd_ctrl = bus_req.rd && (bus_req.addr == `TMR6_ADDR_CTRL);
    assign rd_cmp  = bus_req.rd && (bus_req.addr == `TMR6_ADDR_CMP);

    // upper two control bits read as zero
    assign ctrl_rd_view = {`TMR6_CTRL_PAD, ctrl.start_bit, ctrl.source_clock_select, ctrl.mode_field};

    // unmapped reads answer zero, data valid only the cycle after the strobe
    assign next_rdata = rd_ctrl ? ctrl_rd_view :
                        rd_cmp  ? compare_value_reg :
                                  `TMR6_READ_IDLE;

    // ****************************************
    // control register
    // ****************************************
    // stop entry clears start
    // stop entry wins over a write in the same cycle
    always_comb begin
        next_ctrl = ctrl;
        if (wr_ctrl) begin
            next_ctrl.start_bit           = bus_req.wdata[`TMR6_CTRL_START];
            next_ctrl.source_clock_select = bus_req.wdata[`TMR6_CTRL_SRC_HI:`TMR6_CTRL_SRC_LO];
            next_ctrl.mode_field          = tmr6_mode_t'(bus_req.wdata[`TMR6_CTRL_MODE_HI:`TMR6_CTRL_MODE_LO]);
        end
        if (stop_mode_entry) begin
            next_ctrl.start_bit = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ctrl <= '{start_bit: 1'b0, source_clock_select: 3'h0, mode_field: TMR6_MODE_TIMER};
        end else begin
            ctrl <= next_ctrl;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            compare_value_reg <= CNT_W'(`TMR6_CMP_RESET);
        end else if (wr_cmp) begin
            compare_value_reg <= bus_req.wdata[CNT_W-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rdata <= `TMR6_READ_IDLE;
        end else begin
            rdata <= next_rdata;
        end
    end

    // ****************************************
    // mode decode
    // ****************************************
    // mode field decode
    // reserved code 01 leaves the counter idle
    assign is_timer   = (ctrl.mode_field == TMR6_MODE_TIMER) &&
                        (ctrl.source_clock_select != `TMR6_SRC_EXT);
    assign is_event   = (ctrl.mode_field == TMR6_MODE_TIMER) &&
                        (ctrl.source_clock_select == `TMR6_SRC_EXT) && !low_speed_mode;
    assign is_divider = (ctrl.mode_field == TMR6_MODE_DIVIDER);
    assign is_pwm     = (ctrl.mode_field == TMR6_MODE_PWM) && !low_speed_mode;

    // ****************************************
    // count sources
    // ****************************************
    // internal prescaled tick
    tmr6_prescaler #(
        .PRE_W               (`TMR6_PRE_W)
    ) u_prescaler (
        .clk_sys             (clk_sys),
        .nrst                (nrst),
        .run                 (ctrl.start_bit),
        .low_speed_mode      (low_speed_mode),
        .source_clock_select (ctrl.source_clock_select),
        .tick                (tick)
    );

    tmr6_edge_sync u_event_sync (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .pin_in  (event_input_pin),
        .rise    (ev_rise),
        .fall    (ev_fall)
    );

    // rising edge counts in event mode
    assign count_step = ctrl.start_bit &&
                        ((tick && (is_timer || is_divider || is_pwm)) || (ev_rise && is_event));

    assign count_plus = inc_cnt(counter);

    // ****************************************
    // match detection
    // ****************************************
    // match on reaching compare gives compare ticks
    assign tick_match   = ctrl.start_bit && tick && (is_timer || is_divider) &&
                          (count_plus == compare_value_reg);
    assign event_match  = ctrl.start_bit && is_event && ev_fall && (counter == compare_value_reg);
    assign pwm_overflow = ctrl.start_bit && tick && is_pwm && (counter == CNT_W'(`TMR6_CNT_TOP));
    assign pwm_match    = ctrl.start_bit && tick && is_pwm && !pwm_overflow &&
                          (count_plus == pwm_active_cmp);

    assign clear_hit = tick_match || event_match || pwm_overflow;

    // ****************************************
    // up-counter
    // ****************************************
    // stopped counter held cleared
    always_comb begin
        next_counter = counter;
        if (!ctrl.start_bit) begin
            next_counter = CNT_W'(`TMR6_CNT_ZERO);
        end else if (clear_hit) begin
            next_counter = CNT_W'(`TMR6_CNT_ZERO);
        end else if (count_step) begin
            next_counter = count_plus;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            counter <= CNT_W'(`TMR6_CNT_ZERO);
        end else begin
            counter <= next_counter;
        end
    end

    // ****************************************
    // interrupt pulse
    // ****************************************
    // overflow interrupt same cycle as pin high
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            timer_interrupt <= 1'b0;
        end else begin
            timer_interrupt <= clear_hit;
        end
    end

    // ****************************************
    // pwm compare stages
    // ****************************************
    assign start_rise = ctrl.start_bit && !start_prev;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            start_prev <= 1'b0;
        end else begin
            start_prev <= ctrl.start_bit;
        end
    end

    // a write at overflow is missed: the old compare value is loaded
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pwm_active_cmp <= CNT_W'(`TMR6_CMP_RESET);
        end else if (start_rise || pwm_overflow) begin
            pwm_active_cmp <= compare_value_reg;
        end
    end

    // ****************************************
    // output pins
    // ****************************************
    // toggle on match
    always_comb begin
        next_divider = divider_output_pin;
        if (!ctrl.start_bit || !is_divider) begin
            next_divider = 1'b1;
        end else if (tick_match) begin
            next_divider = !divider_output_pin;
        end
    end

    always_comb begin
        next_pwm_n = pwm_output_pin_n;
        if (!ctrl.start_bit || !is_pwm) begin
            next_pwm_n = 1'b1;
        end else if (pwm_overflow) begin
            next_pwm_n = 1'b1;
        end else if (pwm_match) begin
            next_pwm_n = 1'b0;
        end
    end

    // pins idle high out of reset, as they do while stopped
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            divider_output_pin <= 1'b1;
            pwm_output_pin_n   <= 1'b1;
        end else begin
            divider_output_pin <= next_divider;
            pwm_output_pin_n   <= next_pwm_n;
        end
    end

endmodule

// [bench/tmr6_properties.sv]
`timescale 1ns/100ps
`include "tmr6_defs.svh"
module tmr6_properties
    import tmr6_pkg::*;
(
    input wire logic          clk_sys,
    input wire logic          nrst,
    input wire tmr6_bus_req_t bus_req,
    input wire logic [7:0]    rdata,
    input wire logic          low_speed_mode,
    input wire logic          stop_mode_entry,
    input wire logic          event_input_pin,
    input wire logic          divider_output_pin,
    input wire logic          pwm_output_pin_n,
    input wire logic          timer_interrupt
);
    // ****************************************
    // shadow of the control and compare state
    // ****************************************
    tmr6_ctrl_t ctrl_sh;
    logic [7:0] cmp_sh;
    logic [8:0] gap;
    logic       gap_ok;
    wire        wr_ctrl = bus_req.wr && bus_req.addr == `TMR6_ADDR_CTRL;
    wire        wr_cmp  = bus_req.wr && bus_req.addr == `TMR6_ADDR_CMP;
    wire        run6    = ctrl_sh.start_bit && ctrl_sh.source_clock_select == 3'h6 && !low_speed_mode;
    wire        is_pwm  = ctrl_sh.mode_field == TMR6_MODE_PWM;
    wire        is_div  = ctrl_sh.mode_field == TMR6_MODE_DIVIDER;
    wire        cnt_md  = is_div || ctrl_sh.mode_field == TMR6_MODE_TIMER;
    wire        is_evt  = ctrl_sh.mode_field == TMR6_MODE_TIMER && ctrl_sh.source_clock_select == 3'h7;
    // stop entry written last so it wins
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ctrl_sh <= '0;
            cmp_sh  <= `TMR6_CMP_RESET;
        end else begin
            if (wr_ctrl) ctrl_sh <= tmr6_ctrl_t'(bus_req.wdata[5:0]);
            if (stop_mode_entry) ctrl_sh.start_bit <= 1'b0;
            if (wr_cmp) cmp_sh <= bus_req.wdata;
        end
    end
    // interval measured only between two matches of one run
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            gap    <= '0;
            gap_ok <= 1'b0;
        end else if (!(run6 && cnt_md)) begin
            gap    <= '0;
            gap_ok <= 1'b0;
        end else if (timer_interrupt) begin
            gap    <= 9'h001;
            gap_ok <= 1'b1;
        end else begin
            gap <= gap + 9'h001;
        end
    end
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    ctrl_read_a: assert property (bus_req.rd && bus_req.addr == `TMR6_ADDR_CTRL
        |=> rdata == {2'h0, $past(ctrl_sh)}) else $error("control readback differs");
    stop_pins_a: assert property (!ctrl_sh.start_bit [*2]
        |-> divider_output_pin && pwm_output_pin_n) else $error("pin low while stopped");
    stop_quiet_a: assert property (!ctrl_sh.start_bit [*2] |-> !timer_interrupt)
        else $error("interrupt while stopped");
    div_toggle_a: assert property (ctrl_sh.start_bit && $past(ctrl_sh.start_bit) && is_div
        |-> $changed(divider_output_pin) == timer_interrupt) else $error("divider toggle not at match");
    pwm_high_a: assert property (is_pwm && timer_interrupt |-> pwm_output_pin_n)
        else $error("pwm pin low at overflow");
    pwm_fall_a: assert property ($fell(pwm_output_pin_n) |-> is_pwm && !timer_interrupt)
        else $error("pwm pin fell outside a match");
    pwm_period_a: assert property (run6 && is_pwm && timer_interrupt
        |-> ##256 (timer_interrupt || !(run6 && is_pwm))) else $error("pwm period not 256");
    match_gap_a: assert property (timer_interrupt && gap_ok && run6 && cnt_md
        |-> gap == {1'b0, cmp_sh}) else $error("match interval differs from compare");
    slow_pwm_a: assert property ((low_speed_mode && is_pwm) [*2] |-> pwm_output_pin_n)
        else $error("pwm active in low speed");
    slow_event_a: assert property ((low_speed_mode && ctrl_sh.source_clock_select == 3'h7) [*2]
        |-> !timer_interrupt) else $error("event count in low speed");
    // pin fall, two sync flops, edge detect, then the registered pulse
    event_fall_a: assert property (is_evt && timer_interrupt
        |-> $past(event_input_pin, 4) && !$past(event_input_pin, 3)) else $error("event match not after a fall");
    cover property (run6 && is_pwm && timer_interrupt);
    cover property (is_div && timer_interrupt);
    cover property (ctrl_sh.source_clock_select == 3'h7 && timer_interrupt);
endmodule

bind tmr6_top tmr6_properties chk_u (.clk_sys, .nrst, .bus_req, .rdata, .low_speed_mode, .stop_mode_entry,
    .event_input_pin, .divider_output_pin, .pwm_output_pin_n, .timer_interrupt);

// [bench/tmr6_event_src.sv]
`timescale 1ns/100ps
module tmr6_event_src (
    input  wire logic clk_sys,
    input  wire logic run,
    output logic      event_input_pin
);
    // ****************************************
    // external pulse source
    // ****************************************
    logic [2:0] phase;
    always_ff @(posedge clk_sys) begin
        if (!run) phase <= 3'h0;
        else phase <= phase + 3'h1;
    end
    // four cycles per level
    // stands low between bursts
    assign event_input_pin = run && !phase[2];
endmodule

// [bench/test_timer8_four_mode_counter.sv]
`timescale 1ns/100ps
`include "tmr6_defs.svh"
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin err_total++; \
    $display("wrong value %s expected %0h seen %0h", nm, ex, gt); end end
module test_timer8_four_mode_counter
    import tmr6_pkg::*;
;
    // ****************************************
    // bench
    // ****************************************
    logic          clk_sys;
    logic          nrst;
    tmr6_bus_req_t bus_req;
    logic [7:0]    rdata;
    logic          low_speed_mode;
    logic          stop_mode_entry;
    logic          ev_run;
    logic          event_input_pin;
    logic          divider_output_pin;
    logic          pwm_output_pin_n;
    logic          timer_interrupt;
    int            err_total;
    int            comparisons;
    int            n_irq;
    int            n_plow;
    int            n_dlow;
    int            t;
    localparam logic [7:0] CT = `TMR6_ADDR_CTRL;
    localparam logic [7:0] CM = `TMR6_ADDR_CMP;

    tmr6_top dut_u (.clk_sys(clk_sys), .nrst(nrst), .bus_req(bus_req), .rdata(rdata),
        .low_speed_mode(low_speed_mode), .stop_mode_entry(stop_mode_entry), .event_input_pin(event_input_pin),
        .divider_output_pin(divider_output_pin), .pwm_output_pin_n(pwm_output_pin_n),
        .timer_interrupt(timer_interrupt));
    tmr6_event_src src_u (.clk_sys(clk_sys), .run(ev_run), .event_input_pin(event_input_pin));

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // gap edge after each strobe so no signal is assigned twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus_req <= '{1'b1, 1'b0, a, d};
        @(posedge clk_sys);
        bus_req <= '0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] ex);
        bus_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk_sys);
        bus_req <= '0;
        @(posedge clk_sys);
        `CHK("rdata", ex, rdata)
    endtask
    task automatic watch(input int n);
        n_irq = 0;
        n_plow = 0;
        n_dlow = 0;
        repeat (n) begin
            @(posedge clk_sys);
            n_irq += int'(timer_interrupt === 1'b1);
            n_plow += int'(pwm_output_pin_n === 1'b0);
            n_dlow += int'(divider_output_pin === 1'b0);
        end
    endtask
    task automatic wait_for(input logic want, input int sel);
        int i;
        i = 0;
        do begin
            @(posedge clk_sys);
            i++;
        end while ((sel == 0 ? timer_interrupt : sel == 1 ? pwm_output_pin_n : divider_output_pin) !== want
            && i < 600);
        `CHK("wait", 1, int'(i < 600))
    endtask

    task automatic t_regs;
        rd(CT, 8'h00);
        rd(CM, 8'hFF);
        wr(CT, 8'hDA);
        rd(CT, 8'h1A);
        wr(8'h18, 8'h55);
        rd(8'h18, 8'h00);
        rd(CM, 8'hFF);
        wr(CM, 8'h01);
        rd(CM, 8'h01);
        wr(CT, 8'h00);
        $display("test regs done");
    endtask
    task automatic t_timer;
        wr(CM, 8'h05);
        wr(CT, 8'h38);
        wait_for(1'b1, 0);
        watch(50);
        `CHK("timer_irqs", 10, n_irq)
        wr(CT, 8'h18);
        wr(CM, 8'h02);
        wr(CT, 8'h2C);
        wait_for(1'b1, 0);
        watch(64);
        `CHK("slow_irqs", 4, n_irq)
        wr(CT, 8'h0C);
        rd(CT, 8'h0C);
        watch(20);
        `CHK("stop_irqs", 0, n_irq)
        wr(CT, 8'h39);
        watch(40);
        `CHK("reserved_irqs", 0, n_irq)
        wr(CT, 8'h19);
        $display("test timer done");
    endtask
    // every tap once; the slowest one dominates the run time
    task automatic t_sources;
        int sh [7] = '{`TMR6_SHIFT_SRC0, `TMR6_SHIFT_SRC1, `TMR6_SHIFT_SRC2, `TMR6_SHIFT_SRC3,
                       `TMR6_SHIFT_SRC4, `TMR6_SHIFT_SRC5, `TMR6_SHIFT_SRC6};
        int n;
        wr(CM, 8'h02);
        for (int s = 0; s < 7; s++) begin
            wr(CT, {2'h0, 1'b1, 3'(s), 2'h0});
            n = 0;
            do begin
                @(posedge clk_sys);
                n++;
            end while (timer_interrupt !== 1'b1 && n < 5000);
            n = 0;
            do begin
                @(posedge clk_sys);
                n++;
            end while (timer_interrupt !== 1'b1 && n < 5000);
            `CHK("src_gap", 2 << sh[s], n)
            wr(CT, {2'h0, 1'b0, 3'(s), 2'h0});
        end
        $display("test sources done");
    endtask
    task automatic t_event;
        wr(CM, 8'h03);
        wr(CT, 8'h3C);
        ev_run <= 1'b1;
        watch(96);
        t = n_irq;
        ev_run <= 1'b0;
        watch(10);
        `CHK("event_irqs", 4, t + n_irq)
        wr(CT, 8'h1C);
        low_speed_mode <= 1'b1;
        wr(CT, 8'h3C);
        ev_run <= 1'b1;
        watch(96);
        ev_run <= 1'b0;
        `CHK("slow_event_irqs", 0, n_irq)
        wr(CT, 8'h1C);
        low_speed_mode <= 1'b0;
        $display("test event done");
    endtask
    task automatic t_div;
        wr(CM, 8'h04);
        wr(CT, 8'h3A);
        wait_for(1'b1, 0);
        watch(40);
        `CHK("div_irqs", 10, n_irq)
        `CHK("div_low", 20, n_dlow)
        wait_for(1'b0, 2);
        wr(CT, 8'h1A);
        watch(4);
        `CHK("div_stop_pin", 1'b1, divider_output_pin)
        $display("test divider done");
    endtask
    task automatic t_pwm;
        wr(CM, 8'h40);
        wr(CT, 8'h3B);
        watch(256);
        `CHK("pwm_first_low", 192, n_plow)
        wait_for(1'b1, 0);
        watch(256);
        `CHK("pwm_low1", 192, n_plow)
        `CHK("pwm_irq1", 1, n_irq)
        wr(CM, 8'h80);
        watch(254);
        `CHK("pwm_low2", 192, n_plow)
        watch(256);
        `CHK("pwm_low3", 128, n_plow)
        wait_for(1'b0, 1);
        wr(CT, 8'h1B);
        watch(4);
        `CHK("pwm_stop_pin", 1'b1, pwm_output_pin_n)
        wr(CT, 8'h3B);
        watch(10);
        stop_mode_entry <= 1'b1;
        @(posedge clk_sys);
        stop_mode_entry <= 1'b0;
        rd(CT, 8'h1B);
        low_speed_mode <= 1'b1;
        wr(CT, 8'h3B);
        watch(300);
        `CHK("slow_pwm_low", 0, n_plow)
        `CHK("slow_pwm_irq", 0, n_irq)
        wr(CT, 8'h1B);
        low_speed_mode <= 1'b0;
        $display("test pwm done");
    endtask

    task automatic summarize;
        $display("counts: %0d comparisons, %0d mismatches", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        nrst = 1'b0;
        bus_req = '0;
        low_speed_mode = 1'b0;
        stop_mode_entry = 1'b0;
        ev_run = 1'b0;
        err_total = 0;
        comparisons = 0;
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        t_regs();
        t_timer();
        t_sources();
        t_event();
        t_div();
        t_pwm();
        summarize();
    end

    // about four and a half times the expected run
    initial begin
        #1250000;
        err_total++;
        summarize();
    end
endmodule
